// File: dv/rtcc_tb.sv
// Self-checking bench for the RTC control block, driven over its register bus.
`include "rtcc_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // One compare: counts the check and reports a mismatch at once.
  `define TB_CHK(g, e) \
    begin \
      checks_done++; \
      if ((g) !== (e)) begin \
        error_cnt++; \
        $display("wrong value at %0t ns: got %h want %h", $time, g, e); \
      end \
    end

  logic                       core_clk;
  logic                       sys_rst;
  logic                       core_ce;
  logic                       osc_clk_in;
  rtcc_pkg::rtcc_axi_req_type axi_req;
  rtcc_pkg::rtcc_axi_rsp_type axi_rsp;
  logic                       osc_enable;
  logic                       mcd_enable;
  logic                       alarm_event;
  logic                       osc_fail;
  logic                       irq;
  int                         error_cnt;
  int                         checks_done;

  // A small detector count keeps the missing-clock wait short.
  rtcc_top #(.MCD_CYCLES(8)) rtcc_top_inst (
    .CORE_CLK    (core_clk),
    .SYS_RST     (sys_rst),
    .CORE_CE     (core_ce),
    .OSC_CLK_IN  (osc_clk_in),
    .AXI_REQ     (axi_req),
    .AXI_RSP     (axi_rsp),
    .OSC_ENABLE  (osc_enable),
    .MCD_ENABLE  (mcd_enable),
    .ALARM_EVENT (alarm_event),
    .OSC_FAIL    (osc_fail),
    .IRQ         (irq)
  );

  // The 25 MHz core clock.
  always #20 core_clk = ~core_clk;

  // Write: both channels offered at once, each dropped once it is taken.
  // Handshakes are judged at the falling edge so no race with the slave.
  // No cycle count is assumed; only the watchdog ends a wait.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_t;
    logic w_t;
    logic b_t;
    b_t = 1'b0;
    @(posedge core_clk);
    axi_req.awaddr  <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hf;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    while (!b_t) begin
      @(negedge core_clk);
      aw_t = axi_req.awvalid & axi_rsp.awready;
      w_t  = axi_req.wvalid & axi_rsp.wready;
      b_t  = axi_rsp.bvalid === 1'b1;
      if (b_t) `TB_CHK(axi_rsp.bresp, er)
      @(posedge core_clk);
      if (aw_t) axi_req.awvalid <= 1'b0;
      if (w_t) axi_req.wvalid <= 1'b0;
    end
    axi_req.bready <= 1'b0;
  endtask : bus_wr

  // Read one word and compare data and response.
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    logic ar_t;
    logic r_t;
    r_t = 1'b0;
    @(posedge core_clk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    while (!r_t) begin
      @(negedge core_clk);
      ar_t = axi_req.arvalid & axi_rsp.arready;
      r_t  = axi_rsp.rvalid === 1'b1;
      if (r_t) `TB_CHK({axi_rsp.rresp, axi_rsp.rdata}, {er, ed})
      @(posedge core_clk);
      if (ar_t) axi_req.arvalid <= 1'b0;
    end
    axi_req.rready <= 1'b0;
  endtask : bus_rd

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    bus_wr(a, d, `RTCC_RESP_OKAY);
  endtask : wr_ok

  task automatic rd_ok(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a, e, `RTCC_RESP_OKAY);
  endtask : rd_ok

  // Oscillator cycles, long enough for the two-flop synchroniser.
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge core_clk);
      osc_clk_in <= 1'b1;
      repeat (6) @(posedge core_clk);
      osc_clk_in <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
  endtask : osc

  // Counts, verdict and end of run.
  task automatic give_verdict();
    $display("TB: mismatches %0d compares %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Watchdog: the tests need well under two thousand cycles.
  initial begin
    #(40 * 20000);
    error_cnt++;
    give_verdict();
  end

  // Main sequence; the oscillator pin stays still unless osc() runs.
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    core_ce = 1'b1;
    osc_clk_in = 1'b0;
    axi_req = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_0000);
    rd_ok(`RTCC_ADDR_CAPTURE, 32'h0000_0000);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_00c0);
    @(negedge core_clk);
    `TB_CHK({osc_enable, mcd_enable}, 2'h3)
    // A still oscillator must trip the detector within a few counts.
    repeat (20) @(posedge core_clk);
    `TB_CHK(osc_fail, 1'b1)
    rd_ok(`RTCC_ADDR_STATUS, 32'h0000_0002);
    wr_ok(`RTCC_ADDR_MASK, 32'h0000_0002);
    @(negedge core_clk);
    `TB_CHK(irq, 1'b1)
    wr_ok(`RTCC_ADDR_STATUS, 32'h0000_0002);
    @(negedge core_clk);
    `TB_CHK(irq, 1'b0)
    // Detector off and a one written to the flag: flag must stay.
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_00a0);
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_00a0);
    `TB_CHK(mcd_enable, 1'b0)
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0080);
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_0080);
    // Timer load waits for an oscillator tick, then self-clears.
    wr_ok(`RTCC_ADDR_CAPTURE, 32'h0000_0010);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0082);
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_0082);
    osc(1);
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_0080);
    wr_ok(`RTCC_ADDR_CAPTURE, 32'h0000_0000);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0081);
    osc(1);
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_0080);
    rd_ok(`RTCC_ADDR_CAPTURE, 32'h0000_0010);
    // Five counted ticks, then two held ones.
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0090);
    osc(5);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0080);
    osc(2);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0081);
    osc(1);
    rd_ok(`RTCC_ADDR_CAPTURE, 32'h0000_0015);
    // Alarm with auto-reset: match at the third tick.
    wr_ok(`RTCC_ADDR_ALARM, 32'h0000_0018);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_009c);
    osc(3);
    `TB_CHK(alarm_event, 1'b1)
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_009c);
    osc(1);
    `TB_CHK(alarm_event, 1'b0)
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0080);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0081);
    osc(1);
    rd_ok(`RTCC_ADDR_CAPTURE, 32'h0000_0000);
    // Alarm without auto-reset; bit 2 writes leave the flag alone.
    wr_ok(`RTCC_ADDR_ALARM, 32'h0000_0002);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0098);
    osc(2);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0098);
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_009c);
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0090);
    @(negedge core_clk);
    `TB_CHK(alarm_event, 1'b0)
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_0090);
    // A match with alarms disabled raises nothing.
    wr_ok(`RTCC_ADDR_ALARM, 32'h0000_0003);
    osc(1);
    `TB_CHK(alarm_event, 1'b0)
    rd_ok(`RTCC_ADDR_CONTROL, 32'h0000_0090);
    // Enable low freezes the synchroniser too, so these edges never count.
    core_ce <= 1'b0;
    osc(2);
    core_ce <= 1'b1;
    wr_ok(`RTCC_ADDR_CONTROL, 32'h0000_0081);
    osc(1);
    rd_ok(`RTCC_ADDR_CAPTURE, 32'h0000_0003);
    // Unmapped place: write ignored, read empty, both with an error.
    bus_wr(8'h20, 32'h0000_00ff, `RTCC_RESP_SLVERR);
    bus_rd(8'h20, 32'h0000_0000, `RTCC_RESP_SLVERR);
    give_verdict();
  end

  `undef TB_CHK
endmodule : tb
`default_nettype wire

// File: hw/rtcc_axil.sv
// AXI4-Lite slave that turns bus transfers into one-cycle register strobes.
`include "rtcc_params.svh"
`default_nettype none
module rtcc_axil (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire rtcc_pkg::rtcc_axi_req_type req,
  output var  rtcc_pkg::rtcc_axi_rsp_type rsp,
  output var  rtcc_pkg::rtcc_acc_type     acc,
  input  wire logic                   wr_hit,
  input  wire logic                   rd_hit,
  input  wire logic [31:0]            rd_data
);
  localparam rtcc_pkg::rtcc_slv_type SLV_RST = '{
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    default: '0};
  rtcc_pkg::rtcc_slv_type s_r;
  rtcc_pkg::rtcc_slv_type s_nxt;

  // Address and data are caught independently, so either order works.
  always_comb begin
    s_nxt = s_r;
    if (req.awvalid && s_r.rsp.awready) begin
      s_nxt.rsp.awready = 1'b0;
      s_nxt.aw_got      = 1'b1;
      s_nxt.awaddr      = req.awaddr;
    end
    if (req.wvalid && s_r.rsp.wready) begin
      s_nxt.rsp.wready = 1'b0;
      s_nxt.w_got      = 1'b1;
      s_nxt.wdata      = req.wdata;
      s_nxt.wstrb      = req.wstrb;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got     = 1'b0;
      s_nxt.w_got      = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp  = wr_hit ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
    end
    if (s_r.rsp.bvalid && req.bready) begin
      s_nxt.rsp.bvalid  = 1'b0;
      s_nxt.rsp.awready = 1'b1;
      s_nxt.rsp.wready  = 1'b1;
    end
    if (req.arvalid && s_r.rsp.arready) begin
      s_nxt.rsp.arready = 1'b0;
      s_nxt.ar_got      = 1'b1;
      s_nxt.araddr      = req.araddr;
    end
    if (s_r.ar_got) begin
      s_nxt.ar_got     = 1'b0;
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata  = rd_hit ? rd_data : `RTCC_RST_WORD;
      s_nxt.rsp.rresp  = rd_hit ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
    end
    if (s_r.rsp.rvalid && req.rready) begin
      s_nxt.rsp.rvalid  = 1'b0;
      s_nxt.rsp.arready = 1'b1;
    end
  end

  // Slave state register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= SLV_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Strobes last exactly one enabled cycle because the flags clear then.
  assign rsp = s_r.rsp;
  assign acc = '{wr: s_r.aw_got && s_r.w_got, rd: s_r.ar_got,
                 waddr: s_r.awaddr, raddr: s_r.araddr,
                 wdata: s_r.wdata, wstrb: s_r.wstrb};
endmodule : rtcc_axil
`default_nettype wire

// File: hw/rtcc_sync.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
`default_nettype none
module rtcc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic d,
  output var  logic q
);
  rtcc_pkg::rtcc_sync_type s_r;
  rtcc_pkg::rtcc_sync_type s_nxt;

  // Only the second stage is visible, the first may be metastable.
  always_comb begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  // Both stages clear on reset and freeze while the enable is low.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule : rtcc_sync
`default_nettype wire

// File: hw/rtcc_top.sv
// RTC control register, 32-bit timer, alarm and missing-clock detector.
//
// Our own choice: the AXI4-Lite slave port.
`include "rtcc_params.svh"
`default_nettype none
module rtcc_top #(
  parameter int unsigned MCD_CYCLES = `RTCC_MCD_CYCLES
) (
  input  wire logic                       CORE_CLK,
  input  wire logic                       SYS_RST,
  input  wire logic                       CORE_CE,
  input  wire logic                       OSC_CLK_IN,
  input  wire rtcc_pkg::rtcc_axi_req_type AXI_REQ,
  output var  rtcc_pkg::rtcc_axi_rsp_type AXI_RSP,
  output var  logic                       OSC_ENABLE,
  output var  logic                       MCD_ENABLE,
  output var  logic                       ALARM_EVENT,
  output var  logic                       OSC_FAIL,
  output var  logic                       IRQ
);
  // The detector counter is twelve bits wide and must reach the limit.
  if (MCD_CYCLES < 1 || MCD_CYCLES > 4095) begin : g_chk
    $error("MCD_CYCLES must lie between 1 and 4095.");
  end

  localparam logic [11:0] MCD_FULL = 12'(MCD_CYCLES);
  localparam logic [11:0] MCD_LAST = 12'(MCD_CYCLES - 1);
  localparam rtcc_pkg::rtcc_state_type ST_RST = '{
    ctrl:       `RTCC_RST_CONTROL,
    autoreset:  1'b0,
    capture:    `RTCC_RST_WORD,
    alarm:      `RTCC_RST_WORD,
    timer:      `RTCC_RST_WORD,
    int_st:     `RTCC_RST_NIBBLE,
    int_mask:   `RTCC_RST_NIBBLE,
    irq:        1'b0,
    osc_prev:   1'b0,
    match_prev: 1'b0,
    mcd_cnt:    12'h000};

  rtcc_pkg::rtcc_state_type s_r;
  rtcc_pkg::rtcc_state_type s_nxt;
  rtcc_pkg::rtcc_acc_type   acc;
  logic                     osc_s;
  logic                     tick;
  logic                     edge_any;
  logic                     timeout_hit;
  logic [31:0]              timer_upd;
  logic                     match_nxt;
  logic [3:0]               ev;
  logic                     wr_ctrl;
  logic                     wr_cap;
  logic                     wr_alarm;
  logic                     wr_stat;
  logic                     wr_mask;
  logic                     wr_hit;
  logic                     rd_hit;
  logic [31:0]              rd_data;

  // Byte-lane merge for the word-wide registers.
  function automatic logic [31:0] rtcc_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  st
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : rtcc_merge

  // The oscillator waveform is asynchronous, so it is synchronised first.
  rtcc_sync u_osc_sync (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .ce  (CORE_CE),
    .d   (OSC_CLK_IN),
    .q   (osc_s)
  );

  // Bus slave; it answers unmapped addresses with SLVERR.
  rtcc_axil u_axil (
    .clk     (CORE_CLK),
    .rst     (SYS_RST),
    .ce      (CORE_CE),
    .req     (AXI_REQ),
    .rsp     (AXI_RSP),
    .acc     (acc),
    .wr_hit  (wr_hit),
    .rd_hit  (rd_hit),
    .rd_data (rd_data)
  );

  // Address decode for the write strobe.
  assign wr_ctrl  = acc.wr && acc.waddr == `RTCC_ADDR_CONTROL && acc.wstrb[0];
  assign wr_cap   = acc.wr && acc.waddr == `RTCC_ADDR_CAPTURE;
  assign wr_alarm = acc.wr && acc.waddr == `RTCC_ADDR_ALARM;
  assign wr_stat  = acc.wr && acc.waddr == `RTCC_ADDR_STATUS;
  assign wr_mask  = acc.wr && acc.waddr == `RTCC_ADDR_MASK;
  assign wr_hit   = acc.waddr == `RTCC_ADDR_CONTROL ||
                    acc.waddr == `RTCC_ADDR_CAPTURE ||
                    acc.waddr == `RTCC_ADDR_ALARM ||
                    acc.waddr == `RTCC_ADDR_STATUS ||
                    acc.waddr == `RTCC_ADDR_MASK;

  // Read mux; the control byte shows the live alarm flag in bit 2.
  assign rd_hit  = acc.raddr == `RTCC_ADDR_CONTROL ||
                   acc.raddr == `RTCC_ADDR_CAPTURE ||
                   acc.raddr == `RTCC_ADDR_ALARM ||
                   acc.raddr == `RTCC_ADDR_STATUS ||
                   acc.raddr == `RTCC_ADDR_MASK;
  assign rd_data =
    (acc.raddr == `RTCC_ADDR_CONTROL) ? {24'h000000, s_r.ctrl} :
    (acc.raddr == `RTCC_ADDR_CAPTURE) ? s_r.capture :
    (acc.raddr == `RTCC_ADDR_ALARM)   ? s_r.alarm :
    (acc.raddr == `RTCC_ADDR_STATUS)  ? {28'h0000000, s_r.int_st} :
    (acc.raddr == `RTCC_ADDR_MASK)    ? {28'h0000000, s_r.int_mask} :
    `RTCC_RST_WORD;

  // One oscillator cycle is one rising edge, seen only while it is enabled.
  assign edge_any = osc_s != s_r.osc_prev;
  assign tick     = s_r.ctrl[`RTCC_BIT_OSC_EN] && osc_s && !s_r.osc_prev;

  // A stuck level outlasting the limit fires the detector once.
  assign timeout_hit = s_r.ctrl[`RTCC_BIT_MCD_EN] && !edge_any &&
                       s_r.mcd_cnt == MCD_LAST;

  // Next timer value on a tick: a load beats auto-reset beats counting.
  always_comb begin
    if (s_r.ctrl[`RTCC_BIT_SET]) begin
      timer_upd = s_r.capture;
    end else if (!s_r.ctrl[`RTCC_BIT_RUN]) begin
      timer_upd = s_r.timer;
    end else if (s_r.ctrl[`RTCC_BIT_ALARM] && s_r.autoreset) begin
      timer_upd = `RTCC_RST_WORD;
    end else begin
      timer_upd = s_r.timer + 32'h0000_0001;
    end
  end

  // Matching the new value flags the alarm as soon as the timer gets there.
  assign match_nxt = timer_upd == s_r.alarm;

  // Events that set sticky interrupt status bits.
  assign ev[`RTCC_EV_ALARM] = tick && s_r.ctrl[`RTCC_BIT_AEN] && match_nxt &&
                              !s_r.match_prev;
  assign ev[`RTCC_EV_FAIL]  = timeout_hit;
  assign ev[`RTCC_EV_SET]   = tick && s_r.ctrl[`RTCC_BIT_SET];
  assign ev[`RTCC_EV_CAP]   = tick && s_r.ctrl[`RTCC_BIT_CAP];

  // Next state: oscillator-edge work first, then software writes, then the
  // sticky sets, so that a fail or status event is never lost to a clear.
  always_comb begin
    s_nxt = s_r;
    s_nxt.osc_prev = osc_s;
    // Load and capture requests complete on the next oscillator edge.
    if (tick) begin
      s_nxt.timer      = timer_upd;
      s_nxt.match_prev = match_nxt;
      s_nxt.ctrl[`RTCC_BIT_ALARM] = ev[`RTCC_EV_ALARM];
      s_nxt.ctrl[`RTCC_BIT_SET]   = 1'b0;
      s_nxt.ctrl[`RTCC_BIT_CAP]   = 1'b0;
      if (s_r.ctrl[`RTCC_BIT_CAP]) begin
        s_nxt.capture = s_r.timer;
      end
    end
    // Missing-clock counter restarts on every level change.
    if (!s_r.ctrl[`RTCC_BIT_MCD_EN] || edge_any) begin
      s_nxt.mcd_cnt = 12'h000;
    end else if (s_r.mcd_cnt != MCD_FULL) begin
      s_nxt.mcd_cnt = s_r.mcd_cnt + 12'h001;
    end
    // Control byte write.
    if (wr_ctrl) begin
      s_nxt.ctrl[`RTCC_BIT_OSC_EN] = acc.wdata[`RTCC_BIT_OSC_EN];
      s_nxt.ctrl[`RTCC_BIT_MCD_EN] = acc.wdata[`RTCC_BIT_MCD_EN];
      s_nxt.ctrl[`RTCC_BIT_RUN]    = acc.wdata[`RTCC_BIT_RUN];
      s_nxt.ctrl[`RTCC_BIT_AEN]    = acc.wdata[`RTCC_BIT_AEN];
      s_nxt.autoreset = acc.wdata[`RTCC_BIT_ALARM];
      if (!acc.wdata[`RTCC_BIT_AEN]) begin
        s_nxt.ctrl[`RTCC_BIT_ALARM] = 1'b0;
      end
      if (!acc.wdata[`RTCC_BIT_FAIL]) begin
        s_nxt.ctrl[`RTCC_BIT_FAIL] = 1'b0;
      end
      // A zero cannot cancel a pending request; a one starts a new one.
      if (acc.wdata[`RTCC_BIT_SET]) begin
        s_nxt.ctrl[`RTCC_BIT_SET] = 1'b1;
      end
      if (acc.wdata[`RTCC_BIT_CAP]) begin
        s_nxt.ctrl[`RTCC_BIT_CAP] = 1'b1;
      end
    end
    // Word registers honour byte strobes.
    if (wr_cap) begin
      s_nxt.capture = rtcc_merge(s_nxt.capture, acc.wdata, acc.wstrb);
    end
    if (wr_alarm) begin
      s_nxt.alarm = rtcc_merge(s_r.alarm, acc.wdata, acc.wstrb);
    end
    if (wr_mask && acc.wstrb[0]) begin
      s_nxt.int_mask = acc.wdata[3:0];
    end
    if (wr_stat && acc.wstrb[0]) begin
      s_nxt.int_st = s_r.int_st & ~acc.wdata[3:0];
    end
    // Fail and status sets win over any clear in the same cycle.
    if (timeout_hit) begin
      s_nxt.ctrl[`RTCC_BIT_FAIL] = 1'b1;
    end
    s_nxt.int_st = s_nxt.int_st | ev;
    s_nxt.irq    = |(s_nxt.int_st & s_nxt.int_mask);
  end

  // All state freezes while the clock enable is low.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_r <= ST_RST;
    end else if (CORE_CE) begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from state flops.
  assign OSC_ENABLE  = s_r.ctrl[`RTCC_BIT_OSC_EN];
  assign MCD_ENABLE  = s_r.ctrl[`RTCC_BIT_MCD_EN];
  assign ALARM_EVENT = s_r.ctrl[`RTCC_BIT_ALARM];
  assign OSC_FAIL    = s_r.ctrl[`RTCC_BIT_FAIL];
  assign IRQ         = s_r.irq;

  // Checks on the control behaviour.
  a_osc_enable_wr: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && wr_ctrl |=> OSC_ENABLE == $past(acc.wdata[7]))
    else $error("Oscillator enable did not follow the write.");

  a_mcd_enable_wr: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && wr_ctrl |=> MCD_ENABLE == $past(acc.wdata[6]))
    else $error("Detector enable did not follow the write.");

  a_fail_set: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && timeout_hit |=> OSC_FAIL)
    else $error("Oscillator fail flag missed a timeout.");

  a_fail_sticky: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    OSC_FAIL && !(wr_ctrl && !acc.wdata[`RTCC_BIT_FAIL]) |=> OSC_FAIL)
    else $error("Oscillator fail flag cleared without software.");

  a_timer_count: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && tick && s_r.ctrl[`RTCC_BIT_RUN] &&
    !s_r.ctrl[`RTCC_BIT_SET] && !(ALARM_EVENT && s_r.autoreset)
    |=> s_r.timer == $past(s_r.timer) + 32'h0000_0001)
    else $error("Running timer did not count on a tick.");

  a_timer_hold: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !s_r.ctrl[`RTCC_BIT_RUN] && !s_r.ctrl[`RTCC_BIT_SET]
    |=> s_r.timer == $past(s_r.timer))
    else $error("Stopped timer changed value.");

  a_alarm_fire: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && ev[`RTCC_EV_ALARM] && !wr_ctrl |=> ALARM_EVENT)
    else $error("Alarm match did not raise the flag.");

  a_alarm_read: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && acc.rd && acc.raddr == `RTCC_ADDR_CONTROL
    |=> AXI_RSP.rvalid && AXI_RSP.rdata[2] == $past(ALARM_EVENT))
    else $error("Control read did not show the alarm flag.");

  a_alarm_wr_keep: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && wr_ctrl && !tick && acc.wdata[`RTCC_BIT_AEN]
    |=> ALARM_EVENT == $past(ALARM_EVENT) &&
        s_r.autoreset == $past(acc.wdata[`RTCC_BIT_ALARM]))
    else $error("Write to bit 2 disturbed the alarm flag.");

  a_set_load: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && tick && s_r.ctrl[`RTCC_BIT_SET] && !wr_ctrl
    |=> s_r.timer == $past(s_r.capture) && !s_r.ctrl[`RTCC_BIT_SET])
    else $error("Timer load did not complete on the tick.");

  a_alarm_one_tick: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && tick && ALARM_EVENT |=> !ALARM_EVENT)
    else $error("Alarm flag outlasted one oscillator cycle.");

  a_alarm_clear: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && wr_ctrl && !acc.wdata[`RTCC_BIT_AEN] |=> !ALARM_EVENT)
    else $error("Disabling alarms left the flag set.");

  a_auto_reset: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && tick && ALARM_EVENT && s_r.autoreset &&
    s_r.ctrl[`RTCC_BIT_RUN] && !s_r.ctrl[`RTCC_BIT_SET]
    |=> s_r.timer == 32'h0000_0000)
    else $error("Auto-reset did not clear the timer.");

  a_capture_copy: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && tick && s_r.ctrl[`RTCC_BIT_CAP] && !wr_cap && !wr_ctrl
    |=> s_r.capture == $past(s_r.timer) && !s_r.ctrl[`RTCC_BIT_CAP])
    else $error("Capture did not copy the timer.");

  a_req_wait: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    s_r.ctrl[`RTCC_BIT_SET] && !tick |=> s_r.ctrl[`RTCC_BIT_SET])
    else $error("Load request ended without an oscillator edge.");

  a_irq_level: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    CORE_CE && ev != 4'h0 && (ev & s_r.int_mask) != 4'h0 |=> IRQ)
    else $error("Unmasked event did not raise the interrupt.");
endmodule : rtcc_top
`default_nettype wire

// File: inc/rtcc_params.svh
// Offsets, field positions, reset values and timing counts of the RTC block.
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH
`define RTCC_ADDR_CAPTURE   8'h00
`define RTCC_ADDR_CONTROL   8'h04
`define RTCC_ADDR_ALARM     8'h08
`define RTCC_ADDR_STATUS    8'h0c
`define RTCC_ADDR_MASK      8'h10
`define RTCC_BIT_OSC_EN     7
`define RTCC_BIT_MCD_EN     6
`define RTCC_BIT_FAIL       5
`define RTCC_BIT_RUN        4
`define RTCC_BIT_AEN        3
`define RTCC_BIT_ALARM      2
`define RTCC_BIT_SET        1
`define RTCC_BIT_CAP        0
`define RTCC_EV_ALARM       0
`define RTCC_EV_FAIL        1
`define RTCC_EV_SET         2
`define RTCC_EV_CAP         3
`define RTCC_RST_CONTROL    8'h00
`define RTCC_RST_WORD       32'h0000_0000
`define RTCC_RST_NIBBLE     4'h0
`define RTCC_RESP_OKAY      2'h0
`define RTCC_RESP_SLVERR    2'h2
`define RTCC_CLK_PERIOD_NS  40
`define RTCC_MCD_TIMEOUT_NS 100000
`define RTCC_MCD_CYCLES \
  ((`RTCC_MCD_TIMEOUT_NS + `RTCC_CLK_PERIOD_NS - 1) / `RTCC_CLK_PERIOD_NS)
`endif

// File: inc/rtcc_pkg.sv
// Types shared by the RTC control block and its bus slave.
`default_nettype none
package rtcc_pkg;
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } rtcc_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rtcc_axi_rsp_type;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  waddr;
    logic [7:0]  raddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } rtcc_acc_type;
  typedef struct packed {
    rtcc_axi_rsp_type rsp;
    logic             aw_got;
    logic             w_got;
    logic             ar_got;
    logic [7:0]       awaddr;
    logic [7:0]       araddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
  } rtcc_slv_type;
  typedef struct packed {
    logic s1;
    logic s2;
  } rtcc_sync_type;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        autoreset;
    logic [31:0] capture;
    logic [31:0] alarm;
    logic [31:0] timer;
    logic [3:0]  int_st;
    logic [3:0]  int_mask;
    logic        irq;
    logic        osc_prev;
    logic        match_prev;
    logic [11:0] mcd_cnt;
  } rtcc_state_type;
endpackage : rtcc_pkg
`default_nettype wire
